// ==== hw/txt_ctrl_cfg.svh ====
// Offsets, field positions and reset values of the teletext control bank
`ifndef TXT_CTRL_CFG_SVH
`define TXT_CTRL_CFG_SVH

// Register indexes
`define OFS_ACQ_DISPLAY_CONTROL_A 3'h0
`define OFS_ACQ_SYNC_CONTROL 3'h1
`define OFS_PAGE_REQUEST_SELECT 3'h2
`define OFS_PAGE_REQUEST_DATA 3'h3
`define OFS_OSD_STYLE_CONTROL 3'h4

// Control A fields
`define BIT_EXT_ROW_STORE 0
`define BIT_EXT_ROW_SHOW 1
`define BIT_AUTO_BLANK 2
`define BIT_HDR_ROLL_INH 3
`define BIT_STATUS_ROW_ONLY 4
`define BIT_BLANK_DISABLE 5
`define BIT_VPS_EN 6
`define BIT_INV_EN 7

// Sync control fields
`define BIT_EXT_DEC_INH 0
`define BIT_RAW_DATA 1
`define BIT_CAPTURE_INH 2
`define BIT_ENH_INH 3
`define BIT_ANY_LINE 4
`define BIT_FIELD_POL 5
`define BIT_LINE_SYNC_POL 6
`define BIT_FIELD_SYNC_POL 7

// Page request fields
`define REQ_COL_LSB 0
`define REQ_COL_MSB 2
`define REQ_ENTRY_LSB 3
`define REQ_ENTRY_MSB 6
`define REQ_VALUE_MSB 4
`define REQ_COLUMNS 8
`define REQ_ENTRIES 16

// OSD style fields
`define BIT_BANK_SW 0
`define BIT_QUAD_WIDTH 1
`define BIT_LANG_REGION 2
`define BIT_TALL_SUPPRESS 3
`define BIT_BLACK_MESH 4
`define BIT_COLOUR_MESH 5
`define BIT_BLACK_TRANS 6
`define BIT_SHADOW 7

`define CTRL_RESET 8'h00
`define REQ_RESET 5'h00

`endif

// ==== hw/txt_ctrl_pkg.sv ====
// Types of the teletext control bank
package txt_ctrl_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic ext_row_store_select;
        logic ext_row_show_select;
        logic header_roll_inhibit;
        logic status_row_only;
        logic vps_capture_en;
        logic inventory_capture_en;
        logic extension_decode_inhibit;
        logic raw_data_mode;
        logic capture_write_inhibit;
        logic enhancement_proc_inhibit;
        logic any_line_decode;
        logic field_sync_late;
        logic line_sync_neg;
        logic field_sync_neg;
    } acq_ctrl_t;

    typedef struct packed {
        logic char_bank_switch_en;
        logic quad_width_en;
        logic language_region_sel;
        logic tall_code_suppress;
        logic black_mesh_en;
        logic colour_mesh_en;
        logic black_transparent_en;
        logic shadow_en;
    } osd_ctrl_t;

    typedef struct packed {
        logic [3:0] entry;
        logic [2:0] col;
        logic [4:0] value;
        logic valid;
    } req_write_t;

endpackage

// ==== hw/teletext_acq_display_ctrl.sv ====
// Write-only teletext acquisition and display control bank
// Function
// - Store-select puts packet 24 in extension/page memory; show-select picks row 24 source.
// - Auto blanking bit forces overlay blanking off whenever video is displayed.
// - Header-roll inhibit stops rolling headers and time being written to memory.
// - Status-row-only bit shows row 24 and suppresses all other rows.
// - Blanking-disable bit holds the overlay blanking output permanently low.
// - VPS capture bit enables capture of VPS data lines; clear stops it.
// - Inventory bit collects the inventory page into memory block 8.
// - Extension-packet inhibit bit stops decoding of extension packets.
// - Raw-data bit stores packets 0 to 24 as received, no error checks.
// - Acquisition-off bit blocks all acquisition writes to teletext memory.
// - Packet-26 inhibit bit skips automatic packet 26 processing.
// - Line-range bit: VBI lines only at 0, any line at 1.
// - Field-polarity bit tells which half-line holds even-field sync edge.
// - Line and field sync polarity bits: 0 positive-going, 1 negative-going.
// - Entry and start column select where each 5-bit request write lands.
// - OSD bank bit enables bank switching of display characters.
// - Quad-width bit allows characters at four times normal width.
// - Language-region bit: western handling at 0, eastern at 1.
// - Double-height suppress bit ignores tall codes inside OSD boxes.
// - Two mesh bits mesh black and other-colour background areas.
// - Transparency bit makes black background transparent to video.
// - Shadow bit gives characters a lower-right shadow offset.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "txt_ctrl_cfg.svh"

module teletext_acq_display_ctrl (
    input wire logic mclk, // System clock, 10 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [2:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, one cycle after strobe
    input wire logic video_active, // Video currently being displayed
    input wire logic blank_request, // Display wants overlay blanking
    input wire logic [4:0] disp_row, // Row being displayed
    input wire logic line_sync_in, // Raw line sync pin level
    input wire logic field_sync_in, // Raw field sync pin level
    input wire logic capture_wr_req, // Acquisition memory write request
    input wire logic capture_is_header, // Request carries rolling header/time
    output logic overlay_blank, // Overlay blanking output
    output logic row_visible, // Current row may be shown
    output logic row24_from_ext, // Row 24 shown from extension memory
    output logic capture_wr_en, // Acquisition memory write allowed
    output logic line_sync, // Line sync, active high after polarity
    output logic field_sync, // Field sync, active high after polarity
    output txt_ctrl_pkg::acq_ctrl_t acq_ctrl, // Acquisition controls
    output txt_ctrl_pkg::osd_ctrl_t osd_ctrl, // Display style controls
    output txt_ctrl_pkg::req_write_t req_write // Page request write event
);

    // ==========================================================
    // Control registers
    logic [7:0] acq_display_control_a;
    logic [7:0] acq_sync_control;
    logic [7:0] page_request_select;
    logic [7:0] osd_style_control;
    logic [2:0] next_col;
    logic [4:0] req_table [0:`REQ_ENTRIES-1][0:`REQ_COLUMNS-1];
    txt_ctrl_pkg::reg_req_t bus;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acq_display_control_a <= `CTRL_RESET;
        end else if (bus.wr && bus.addr == `OFS_ACQ_DISPLAY_CONTROL_A) begin
            acq_display_control_a <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acq_sync_control <= `CTRL_RESET;
        end else if (bus.wr && bus.addr == `OFS_ACQ_SYNC_CONTROL) begin
            acq_sync_control <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osd_style_control <= `CTRL_RESET;
        end else if (bus.wr && bus.addr == `OFS_OSD_STYLE_CONTROL) begin
            osd_style_control <= bus.wdata;
        end
    end

    // ==========================================================
    // Page request loading
    assign next_col = page_request_select[`REQ_COL_MSB:`REQ_COL_LSB] + 3'h1;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            page_request_select <= `CTRL_RESET;
        end else if (bus.wr && bus.addr == `OFS_PAGE_REQUEST_SELECT) begin
            page_request_select <= {1'b0, bus.wdata[6:0]};
        end else if (bus.wr && bus.addr == `OFS_PAGE_REQUEST_DATA) begin
            page_request_select[`REQ_COL_MSB:`REQ_COL_LSB] <= next_col;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_write <= '0;
        end else begin
            req_write.valid <= bus.wr && bus.addr == `OFS_PAGE_REQUEST_DATA;
            req_write.entry <= page_request_select[`REQ_ENTRY_MSB:`REQ_ENTRY_LSB];
            req_write.col <= page_request_select[`REQ_COL_MSB:`REQ_COL_LSB];
            req_write.value <= bus.wdata[`REQ_VALUE_MSB:0];
        end
    end

    genvar ge, gc;
    generate
        for (ge = 0; ge < `REQ_ENTRIES; ge++) begin : g_entry
            for (gc = 0; gc < `REQ_COLUMNS; gc++) begin : g_col
                always_ff @(posedge mclk or posedge rst) begin
                    if (rst) begin
                        req_table[ge][gc] <= `REQ_RESET;
                    end else if (bus.wr && bus.addr == `OFS_PAGE_REQUEST_DATA
                                 && page_request_select[`REQ_ENTRY_MSB:`REQ_ENTRY_LSB]
                                    == 4'(ge)
                                 && page_request_select[`REQ_COL_MSB:`REQ_COL_LSB]
                                    == 3'(gc)) begin
                        req_table[ge][gc] <= bus.wdata[`REQ_VALUE_MSB:0];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read port: registers are write-only, reads give zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Acquisition controls
    always_comb begin
        acq_ctrl.ext_row_store_select = acq_display_control_a[`BIT_EXT_ROW_STORE];
        acq_ctrl.ext_row_show_select = acq_display_control_a[`BIT_EXT_ROW_SHOW];
        acq_ctrl.header_roll_inhibit = acq_display_control_a[`BIT_HDR_ROLL_INH];
        acq_ctrl.status_row_only = acq_display_control_a[`BIT_STATUS_ROW_ONLY];
        acq_ctrl.vps_capture_en = acq_display_control_a[`BIT_VPS_EN];
        acq_ctrl.inventory_capture_en = acq_display_control_a[`BIT_INV_EN];
        acq_ctrl.extension_decode_inhibit = acq_sync_control[`BIT_EXT_DEC_INH];
        acq_ctrl.raw_data_mode = acq_sync_control[`BIT_RAW_DATA];
        acq_ctrl.capture_write_inhibit = acq_sync_control[`BIT_CAPTURE_INH];
        acq_ctrl.enhancement_proc_inhibit = acq_sync_control[`BIT_ENH_INH];
        acq_ctrl.any_line_decode = acq_sync_control[`BIT_ANY_LINE];
        acq_ctrl.field_sync_late = acq_sync_control[`BIT_FIELD_POL];
        acq_ctrl.line_sync_neg = acq_sync_control[`BIT_LINE_SYNC_POL];
        acq_ctrl.field_sync_neg = acq_sync_control[`BIT_FIELD_SYNC_POL];
    end

    // Memory write gate: acquisition-off beats everything
    assign capture_wr_en = capture_wr_req && !acq_sync_control[`BIT_CAPTURE_INH]
        && !(capture_is_header && acq_display_control_a[`BIT_HDR_ROLL_INH]);

    assign line_sync = line_sync_in ^ acq_sync_control[`BIT_LINE_SYNC_POL];
    assign field_sync = field_sync_in ^ acq_sync_control[`BIT_FIELD_SYNC_POL];

    // ==========================================================
    // Display controls
    assign row24_from_ext = acq_display_control_a[`BIT_EXT_ROW_SHOW];
    assign row_visible = !acq_display_control_a[`BIT_STATUS_ROW_ONLY]
        || disp_row == 5'h18;

    // Disable wins over auto and request
    assign overlay_blank = !acq_display_control_a[`BIT_BLANK_DISABLE]
        && blank_request
        && !(acq_display_control_a[`BIT_AUTO_BLANK] && video_active);

    always_comb begin
        osd_ctrl.char_bank_switch_en = osd_style_control[`BIT_BANK_SW];
        osd_ctrl.quad_width_en = osd_style_control[`BIT_QUAD_WIDTH];
        osd_ctrl.language_region_sel = osd_style_control[`BIT_LANG_REGION];
        osd_ctrl.tall_code_suppress = osd_style_control[`BIT_TALL_SUPPRESS];
        osd_ctrl.black_mesh_en = osd_style_control[`BIT_BLACK_MESH];
        osd_ctrl.colour_mesh_en = osd_style_control[`BIT_COLOUR_MESH];
        osd_ctrl.black_transparent_en = osd_style_control[`BIT_BLACK_TRANS];
        osd_ctrl.shadow_en = osd_style_control[`BIT_SHADOW];
    end

endmodule

// ==== tb/txt_ctrl_sva.sv ====
// Port checker of the teletext control bank
`timescale 1ns/1ns
module txt_ctrl_sva (
    input logic mclk, rst, reg_wr, reg_rd, video_active, blank_request, line_sync_in,
    input logic field_sync_in, capture_wr_req, capture_is_header, overlay_blank, row_visible,
    input logic row24_from_ext, capture_wr_en, line_sync, field_sync,
    input logic [2:0] reg_addr,
    input logic [7:0] reg_wdata, reg_rdata,
    input logic [4:0] disp_row,
    input txt_ctrl_pkg::acq_ctrl_t acq_ctrl,
    input txt_ctrl_pkg::osd_ctrl_t osd_ctrl,
    input txt_ctrl_pkg::req_write_t req_write
);
    // ==========================================
    // Write decodes
    logic wr_a, wr_s, wr_p, wr_d, wr_o;
    assign wr_a = reg_wr && reg_addr == 3'h0;
    assign wr_s = reg_wr && reg_addr == 3'h1;
    assign wr_p = reg_wr && reg_addr == 3'h2;
    assign wr_d = reg_wr && reg_addr == 3'h3;
    assign wr_o = reg_wr && reg_addr == 3'h4;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================
    // Assertions
    a_row24_select: assert property (wr_a |=> row24_from_ext == $past(reg_wdata[1]) &&
        acq_ctrl.ext_row_store_select == $past(reg_wdata[0])) else $error("row 24 select");
    a_auto_blank: assert property (wr_a && reg_wdata[2] ##1 video_active |-> !overlay_blank)
        else $error("auto blanking");
    a_capture_gate: assert property (capture_wr_en == (capture_wr_req &&
        !acq_ctrl.capture_write_inhibit && !(acq_ctrl.header_roll_inhibit && capture_is_header)))
        else $error("capture gate");
    a_status_row: assert property (row_visible ==
        (!acq_ctrl.status_row_only || disp_row == 5'h18)) else $error("status row");
    a_blank_low: assert property (wr_a && reg_wdata[5] |=> !overlay_blank)
        else $error("blanking not low");
    a_sync_sense: assert property ({line_sync, field_sync} ==
        {line_sync_in ^ acq_ctrl.line_sync_neg, field_sync_in ^ acq_ctrl.field_sync_neg})
        else $error("sync polarity");
    a_sync_fields: assert property (wr_s |=> acq_ctrl.raw_data_mode == $past(reg_wdata[1]) &&
        acq_ctrl.field_sync_late == $past(reg_wdata[5])) else $error("sync fields");
    a_osd_fields: assert property (wr_o |=> osd_ctrl.char_bank_switch_en == $past(reg_wdata[0]) &&
        osd_ctrl.shadow_en == $past(reg_wdata[7])) else $error("osd fields");
    a_osd_hold: assert property (!wr_o |=> $stable(osd_ctrl)) else $error("osd changed");
    a_req_pulse: assert property (wr_d |=> req_write.valid &&
        req_write.value == $past(reg_wdata[4:0])) else $error("request pulse");
    a_req_start: assert property (wr_p ##1 wr_d |=> req_write.entry == $past(reg_wdata[6:3], 2) &&
        req_write.col == $past(reg_wdata[2:0], 2)) else $error("request start");
    a_req_advance: assert property (wr_d ##1 wr_d |=>
        req_write.col == $past(req_write.col) + 3'h1) else $error("request column");
    c_req_burst: cover property (wr_d ##1 wr_d);
    c_status_row: cover property (acq_ctrl.status_row_only && row_visible);
    c_auto_blank: cover property (wr_a && reg_wdata[2] ##1 video_active);
endmodule

bind teletext_acq_display_ctrl txt_ctrl_sva chk_u (
    .mclk(mclk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .video_active(video_active),
    .blank_request(blank_request),
    .line_sync_in(line_sync_in),
    .field_sync_in(field_sync_in),
    .capture_wr_req(capture_wr_req),
    .capture_is_header(capture_is_header),
    .overlay_blank(overlay_blank),
    .row_visible(row_visible),
    .row24_from_ext(row24_from_ext),
    .capture_wr_en(capture_wr_en),
    .line_sync(line_sync),
    .field_sync(field_sync),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .disp_row(disp_row),
    .acq_ctrl(acq_ctrl),
    .osd_ctrl(osd_ctrl),
    .req_write(req_write)
);

// ==== tb/teletext_acq_display_ctrl_tb_top.sv ====
// Self-checking bench of the teletext control bank
`timescale 1ns/1ns
module teletext_acq_display_ctrl_tb_top;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, video_active = 1'b0;
    logic blank_request = 1'b0, line_sync_in = 1'b0, field_sync_in = 1'b0;
    logic capture_wr_req = 1'b0, capture_is_header = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [4:0] disp_row = 5'h00;
    logic [7:0] reg_rdata;
    logic overlay_blank, row_visible, row24_from_ext, capture_wr_en, line_sync, field_sync;
    txt_ctrl_pkg::acq_ctrl_t acq_ctrl;
    txt_ctrl_pkg::osd_ctrl_t osd_ctrl;
    txt_ctrl_pkg::req_write_t req_write;
    int err_total = 0;
    int n_checks = 0;

    always #50 mclk = ~mclk;

    teletext_acq_display_ctrl dut_u (
        .mclk(mclk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .video_active(video_active),
        .blank_request(blank_request),
        .disp_row(disp_row),
        .line_sync_in(line_sync_in),
        .field_sync_in(field_sync_in),
        .capture_wr_req(capture_wr_req),
        .capture_is_header(capture_is_header),
        .overlay_blank(overlay_blank),
        .row_visible(row_visible),
        .row24_from_ext(row24_from_ext),
        .capture_wr_en(capture_wr_en),
        .line_sync(line_sync),
        .field_sync(field_sync),
        .acq_ctrl(acq_ctrl),
        .osd_ctrl(osd_ctrl),
        .req_write(req_write)
    );

    // ==========================================
    // Bus and compare tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic idle();
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        idle();
        chk(reg_rdata, 16'h0000);
    endtask

    // Struct fields run opposite to register bits
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction

    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        finish_test();
    end

    // ==========================================
    // Test sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        blank_request <= 1'b1;
        video_active <= 1'b1;
        disp_row <= 5'h03;
        capture_wr_req <= 1'b1;
        capture_is_header <= 1'b1;
        #1 chk(32'({acq_ctrl, osd_ctrl}), 32'h0000_0000);
        chk({overlay_blank, row_visible, capture_wr_en}, 16'h0007);
        wr(3'h0, 8'h22);
        idle();
        chk({overlay_blank, row24_from_ext}, 16'h0001);
        wr(3'h0, 8'h04);
        idle();
        chk(overlay_blank, 16'h0000);
        @(posedge mclk);
        video_active <= 1'b0;
        #1 chk(overlay_blank, 16'h0001);
        wr(3'h0, 8'h18);
        idle();
        chk({row_visible, capture_wr_en}, 16'h0000);
        @(posedge mclk);
        disp_row <= 5'h18;
        capture_is_header <= 1'b0;
        #1 chk({row_visible, capture_wr_en}, 16'h0003);
        wr(3'h0, 8'hC1);
        idle();
        chk({acq_ctrl.vps_capture_en, acq_ctrl.inventory_capture_en}, 16'h0003);
        chk({acq_ctrl.ext_row_store_select, row24_from_ext}, 16'h0002);
        wr(3'h1, 8'h04);
        idle();
        chk(capture_wr_en, 16'h0000);
        wr(3'h0, 8'h00);
        idle();
        chk({acq_ctrl.vps_capture_en, acq_ctrl.inventory_capture_en}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(3'h1, 8'h01 << i);
            wr(3'h4, 8'h01 << i);
            idle();
            chk(rev8(acq_ctrl[7:0]), 8'h01 << i);
            chk(rev8(osd_ctrl), 8'h01 << i);
        end
        wr(3'h5, 8'hFF);
        idle();
        chk({rev8(acq_ctrl[7:0]), rev8(osd_ctrl)}, 16'h8080);
        @(posedge mclk);
        line_sync_in <= 1'b1;
        wr(3'h1, 8'hC0);
        idle();
        chk({line_sync, field_sync}, 16'h0001);
        rd(3'h0);
        rd(3'h7);
        wr(3'h2, 8'h2F);
        wr(3'h3, 8'h11);
        wr(3'h3, 8'hE2);
        idle();
        chk({req_write.valid, req_write.entry, req_write.col, req_write.value}, 16'h1502);
        wr(3'h2, 8'h2F);
        wr(3'h3, 8'h0A);
        idle();
        chk({req_write.valid, req_write.entry, req_write.col, req_write.value}, 16'h15EA);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1 chk(32'({acq_ctrl, osd_ctrl}), 32'h0000_0000);
        finish_test();
    end
endmodule
